// file: src/flash_prot_defs.vh
// Constants for the flash access and write protection block
`ifndef FLASH_PROT_DEFS_VH
`define FLASH_PROT_DEFS_VH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_SECTOR_LOCK_NV      22'h08DFB0
`define IDX_ACCESS_LOCK_NV      22'h08DFB8
`define IDX_UNLOCK_SLOTS_NV     22'h08DFBC
`define IDX_RELOCK_SLOTS_NV     22'h08DFBE
`define IDX_TEMP_UNLOCK_CTRL    22'h08DFC0
`define IDX_SETPROT_TARGET      22'h08DFC2
`define IDX_SETPROT_DATA        22'h08DFC4
`define IDX_SETPROT_START       22'h08DFC6
`define IDX_PROT_STATUS         22'h08DFC8
`define IDX_LSB                 2
`define IDX_W                   22

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACC_LOCK_BIT            0
`define DBG_LOCK_BIT            1
`define TEMP_UNLOCK_BIT         0
`define SETPROT_GO_BIT          0
`define ST_PROTECTED_BIT        0
`define ST_DEBUG_EN_BIT         1
`define ST_READY_BIT            2
`define ST_SP_REJECT_BIT        3
`define ST_LOCK_EFF_BIT         4
`define ST_SECTOR_LSB           8

// ----------------------------------------
// Reset and delivery values
// ----------------------------------------
`define ACCESS_LOCK_DELIVERY    16'hACFF
`define SLOTS_DELIVERY          16'hFFFF
`define SECTOR_DELIVERY         8'hFF
`define ACC_FIELD_MASK          16'h0003
`define DUMMY_READ_DATA         16'h0000
`define SW_TRAP_NUMBER          16'h009B

// ----------------------------------------
// Reset sequencer states (one-hot)
// ----------------------------------------
`define ST_W                    3
`define S_FORCE                 3'h1
`define S_LOAD                  3'h2
`define S_RUN                   3'h4

`endif

// file: src/flash_access_write_protection.v
// Flash access, debug and sector write protection with APB register access
//
// Local design decision: the APB register port.
`include "flash_prot_defs.vh"

// Contract
// - Data lock at 0 blocks flash data access unless fetching from flash.
// - Debug lock 1 allows debug bypass; 0 disables debug, test interface, test modes.
// - Unlock bit x at 0 with relock bit x at 1 cancels the data lock.
// - Unlock bit 0 programmable only after debug and data lock bits are zero.
// - Unlock bit x programmable only after relock bit x-1 is zero.
// - Relock bit x at 0 with unlock bit x+1 at 1 restores the data lock.
// - Relock bit x programmable only after unlock bit x is zero.
// - Temporary-unlock bit at 1 suspends access protection.
// - Temporary-unlock bit writable only by code fetched from flash.
// - Protected exactly when data lock and temporary-unlock are both zero.
// - Sixteen unlock/relock slot pairs limit permanent disable/enable rounds.
// - When protected, flash writes from RAM or external code are discarded.
// - When protected, reads from RAM or external code give dummy data and trap.
// - When protected, event channel flash transfers are refused.
// - When protected, flash control register writes are blocked.
// - Sector with write lock at 0 cannot be programmed or erased.
// - Set-protection writing 1 to sector lock sets only the volatile copy.
// - Sector locks restored by reset or set-protection writing 0.
// - Access protection restored by reset or clearing temporary-unlock bit.
// - Reset forces all protections, then copies non-volatile bits once.
// - Set-protection runs only when launched from memory other than flash.
module flash_access_write_protection #(
	parameter NSLOT = 16,
	parameter NSECT = 8,
	parameter DW    = 16
) (
	input  wire                   core_clk,
	input  wire                   resetn,
	// APB slave
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [23:0]            paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output wire                   pready,
	output wire                   pslverr,
	// Fetch origin of the instruction issuing the current register access
	input  wire                   cpu_fetch_flash,
	// Flash data access from CPU or event transfer channel
	input  wire                   acc_req,
	input  wire                   acc_write,
	input  wire                   acc_from_evt,
	input  wire                   acc_fetch_flash,
	input  wire                   acc_debug,
	input  wire [DW-1:0]          flash_rdata,
	output wire                   flash_rd_en,
	output wire                   flash_wr_en,
	output reg                    acc_done_r,
	output reg                    acc_refused_r,
	output reg  [DW-1:0]          acc_rdata_r,
	output reg                    trap_req_r,
	output reg  [DW-1:0]          trap_num_r,
	// Program/erase sector check from the flash controller
	input  wire                   prog_req,
	input  wire [2:0]             prog_sector,
	output wire                   prog_allow,
	// Flash control register write qualifier
	output wire                   ctrl_wr_allow,
	// Debug and test access enable
	output reg                    debug_enable_r
);

	// ----------------------------------------
	// Non-volatile cells and volatile copies
	// ----------------------------------------
	reg  [DW-1:0]    acc_nv_r;
	reg  [NSLOT-1:0] unlock_nv_r;
	reg  [NSLOT-1:0] relock_nv_r;
	reg  [NSECT-1:0] sector_nv_r;
	reg              acc_lock_v_r;
	reg              dbg_lock_v_r;
	reg  [NSLOT-1:0] unlock_v_r;
	reg  [NSLOT-1:0] relock_v_r;
	reg  [NSECT-1:0] sector_v_r;
	reg              temp_unlock_r;
	reg  [`IDX_W-1:0] sp_target_r;
	reg  [DW-1:0]    sp_data_r;
	reg              sp_reject_r;
	reg  [`ST_W-1:0] state_r;
	reg  [`ST_W-1:0] state_nxt;

	wire [`IDX_W-1:0] idx = paddr[`IDX_LSB +: `IDX_W];

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire hit_sector = (idx == `IDX_SECTOR_LOCK_NV);
	wire hit_access = (idx == `IDX_ACCESS_LOCK_NV);
	wire hit_unlock = (idx == `IDX_UNLOCK_SLOTS_NV);
	wire hit_relock = (idx == `IDX_RELOCK_SLOTS_NV);
	wire hit_temp   = (idx == `IDX_TEMP_UNLOCK_CTRL);
	wire hit_target = (idx == `IDX_SETPROT_TARGET);
	wire hit_data   = (idx == `IDX_SETPROT_DATA);
	wire hit_start  = (idx == `IDX_SETPROT_START);
	wire hit_status = (idx == `IDX_PROT_STATUS);

	// Target of a pending set-protection
	wire sp_to_access = (sp_target_r == `IDX_ACCESS_LOCK_NV);
	wire sp_to_unlock = (sp_target_r == `IDX_UNLOCK_SLOTS_NV);
	wire sp_to_relock = (sp_target_r == `IDX_RELOCK_SLOTS_NV);
	wire sp_to_sector = (sp_target_r == `IDX_SECTOR_LOCK_NV);

	wire             wr_acc = psel & penable & pwrite;
	wire             loading = state_r[1];
	wire             running = state_r[2];
	wire             sp_go = wr_acc & hit_start & pwdata[`SETPROT_GO_BIT];

	// ----------------------------------------
	// Protection state
	// ----------------------------------------
	// A slot pair cancels the lock while its unlock bit is spent and its relock is not
	wire lock_cancel = |(~unlock_v_r & relock_v_r);
	wire lock_eff = ~acc_lock_v_r & ~lock_cancel;
	wire protected_w = lock_eff & ~temp_unlock_r;

	// ----------------------------------------
	// Set-protection candidate values
	// ----------------------------------------
	// Each slot bit may only fall when its predecessor in the chain is already spent
	wire [NSLOT-1:0] unlock_req = unlock_nv_r & sp_data_r[NSLOT-1:0];
	wire [NSLOT-1:0] relock_req = relock_nv_r & sp_data_r[NSLOT-1:0];
	wire [NSLOT-1:0] unlock_ok;
	wire [NSLOT-1:0] relock_ok;
	genvar g;
	generate
		for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
			if (g == 0) begin : g_first
				assign unlock_ok[g] = ~acc_nv_r[`ACC_LOCK_BIT] & ~acc_nv_r[`DBG_LOCK_BIT];
			end else begin : g_rest
				assign unlock_ok[g] = ~relock_nv_r[g-1];
			end
			assign relock_ok[g] = ~unlock_nv_r[g];
		end
	endgenerate

	// Bits not allowed to fall keep their old value
	wire [NSLOT-1:0] unlock_new = unlock_nv_r & (unlock_req | ~unlock_ok);
	wire [NSLOT-1:0] relock_new = relock_nv_r & (relock_req | ~relock_ok);
	wire [NSLOT-1:0] unlock_bad = unlock_nv_r & ~unlock_req & ~unlock_ok;
	wire [NSLOT-1:0] relock_bad = relock_nv_r & ~relock_req & ~relock_ok;
	wire [DW-1:0]    acc_new = acc_nv_r & (sp_data_r | ~`ACC_FIELD_MASK);

	// Launch from flash or while protected is refused outright
	wire sp_launch_ok = running & ~cpu_fetch_flash & ~protected_w;
	wire sp_exec = sp_go & sp_launch_ok;

	// A partly barred chain write still lands its legal bits but is flagged
	wire unlock_chain_bad = sp_to_unlock & (|unlock_bad);
	wire relock_chain_bad = sp_to_relock & (|relock_bad);
	wire sp_refused       = ~sp_launch_ok | unlock_chain_bad | relock_chain_bad;

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	always @* begin
		case (state_r)
			`S_FORCE: state_nxt = `S_LOAD;
			`S_LOAD:  state_nxt = `S_RUN;
			`S_RUN:   state_nxt = `S_RUN;
			default:  state_nxt = `S_FORCE;
		endcase
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= `S_FORCE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// Non-volatile cells (model of the fuse array)
	// ----------------------------------------
	// Only cleared by set-protection, which can program 1 to 0, never erase; reset reloads the delivery values
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			acc_nv_r <= `ACCESS_LOCK_DELIVERY;
		end else if (sp_exec && sp_to_access) begin
			acc_nv_r <= acc_new;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			unlock_nv_r <= `SLOTS_DELIVERY;
		end else if (sp_exec && sp_to_unlock) begin
			unlock_nv_r <= unlock_new;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			relock_nv_r <= `SLOTS_DELIVERY;
		end else if (sp_exec && sp_to_relock) begin
			relock_nv_r <= relock_new;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sector_nv_r <= `SECTOR_DELIVERY;
		end else if (sp_exec && sp_to_sector) begin
			sector_nv_r <= sector_nv_r & sp_data_r[NSECT-1:0];
		end
	end

	// ----------------------------------------
	// Volatile copies that govern operation
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			// Everything locked until the cells have been read
			acc_lock_v_r <= 1'b0;
			dbg_lock_v_r <= 1'b0;
		end else if (loading) begin
			acc_lock_v_r <= acc_nv_r[`ACC_LOCK_BIT];
			dbg_lock_v_r <= acc_nv_r[`DBG_LOCK_BIT];
		end else if (sp_exec && sp_to_access) begin
			acc_lock_v_r <= acc_new[`ACC_LOCK_BIT];
			dbg_lock_v_r <= acc_new[`DBG_LOCK_BIT];
		end
	end

	// All slots spent-free at reset, so no pair cancels the lock early
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			unlock_v_r <= `SLOTS_DELIVERY;
		end else if (loading) begin
			unlock_v_r <= unlock_nv_r;
		end else if (sp_exec && sp_to_unlock) begin
			unlock_v_r <= unlock_new;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			relock_v_r <= `SLOTS_DELIVERY;
		end else if (loading) begin
			relock_v_r <= relock_nv_r;
		end else if (sp_exec && sp_to_relock) begin
			relock_v_r <= relock_new;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sector_v_r <= {NSECT{1'b0}};
		end else if (loading) begin
			sector_v_r <= sector_nv_r[NSECT-1:0];
		end else if (sp_exec && sp_to_sector) begin
			// Ones lift the volatile lock only; zeros relock
			sector_v_r <= sp_data_r[NSECT-1:0];
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			debug_enable_r <= 1'b0;
		end else begin
			debug_enable_r <= running & dbg_lock_v_r;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			temp_unlock_r <= 1'b0;
			sp_target_r   <= {`IDX_W{1'b0}};
			sp_data_r     <= {DW{1'b0}};
			sp_reject_r   <= 1'b0;
		end else begin
			// Ignored unless the writer runs from flash, so RAM code cannot unprotect
			if (wr_acc && idx == `IDX_TEMP_UNLOCK_CTRL && cpu_fetch_flash) begin
				temp_unlock_r <= pwdata[`TEMP_UNLOCK_BIT];
			end
			if (wr_acc && idx == `IDX_SETPROT_TARGET && !protected_w) begin
				sp_target_r <= pwdata[`IDX_W-1:0];
			end
			if (wr_acc && idx == `IDX_SETPROT_DATA && !protected_w) begin
				sp_data_r <= pwdata[DW-1:0];
			end
			if (sp_go) begin
				sp_reject_r <= sp_refused;
			end
		end
	end

	// ----------------------------------------
	// APB read side
	// ----------------------------------------
	wire mapped = (idx == `IDX_SECTOR_LOCK_NV) | (idx == `IDX_ACCESS_LOCK_NV) |
		(idx == `IDX_UNLOCK_SLOTS_NV) | (idx == `IDX_RELOCK_SLOTS_NV) |
		(idx == `IDX_TEMP_UNLOCK_CTRL) | (idx == `IDX_SETPROT_TARGET) |
		(idx == `IDX_SETPROT_DATA) | (idx == `IDX_SETPROT_START) | (idx == `IDX_PROT_STATUS);

	// Status word; software tracks temporary sector unlocks only here
	reg [31:0] status_word;
	always @* begin
		status_word = 32'h0000_0000;
		status_word[`ST_PROTECTED_BIT] = protected_w;
		status_word[`ST_DEBUG_EN_BIT]  = debug_enable_r;
		status_word[`ST_READY_BIT]     = running;
		status_word[`ST_SP_REJECT_BIT] = sp_reject_r;
		status_word[`ST_LOCK_EFF_BIT]  = lock_eff;
		status_word[`ST_SECTOR_LSB +: NSECT] = sector_v_r;
	end

	// Zero wait: every register answers in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always @* begin
		prdata = 32'h0000_0000;
		case (idx)
			// Non-volatile view: a temporary sector unlock does not show here
			`IDX_SECTOR_LOCK_NV:   prdata[NSECT-1:0] = sector_nv_r;
			`IDX_ACCESS_LOCK_NV:   prdata[DW-1:0] = acc_nv_r;
			`IDX_UNLOCK_SLOTS_NV:  prdata[NSLOT-1:0] = unlock_nv_r;
			`IDX_RELOCK_SLOTS_NV:  prdata[NSLOT-1:0] = relock_nv_r;
			`IDX_TEMP_UNLOCK_CTRL: prdata[`TEMP_UNLOCK_BIT] = temp_unlock_r;
			`IDX_SETPROT_TARGET:   prdata[`IDX_W-1:0] = sp_target_r;
			`IDX_SETPROT_DATA:     prdata[DW-1:0] = sp_data_r;
			`IDX_PROT_STATUS:      prdata = status_word;
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Data access qualification
	// ----------------------------------------
	// Event channel gets no flash-fetch exemption; debug bypass only while enabled
	wire acc_open      = ~protected_w;
	wire acc_from_code = acc_fetch_flash & ~acc_from_evt;
	wire acc_dbg_ok    = acc_debug & debug_enable_r;
	// Nothing passes before the volatile copies have been loaded
	wire acc_allowed   = running & (acc_open | acc_from_code | acc_dbg_ok);

	assign flash_rd_en = acc_req & ~acc_write & acc_allowed;
	assign flash_wr_en = acc_req & acc_write & acc_allowed;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			acc_done_r    <= 1'b0;
			acc_refused_r <= 1'b0;
			acc_rdata_r   <= {DW{1'b0}};
			trap_req_r    <= 1'b0;
			trap_num_r    <= {DW{1'b0}};
		end else begin
			acc_done_r    <= acc_req;
			acc_refused_r <= acc_req & ~acc_allowed;
			trap_req_r    <= acc_req & ~acc_write & ~acc_allowed & ~acc_from_evt;
			trap_num_r    <= `SW_TRAP_NUMBER;
			if (acc_req && !acc_write) begin
				acc_rdata_r <= acc_allowed ? flash_rdata : `DUMMY_READ_DATA;
			end
		end
	end

	// ----------------------------------------
	// Program/erase gating
	// ----------------------------------------
	assign ctrl_wr_allow = running & ~protected_w;
	assign prog_allow = prog_req & ctrl_wr_allow & sector_v_r[prog_sector];

endmodule

// file: bench/flash_prot_assertions.sv
// Checker: protection relations seen at the block's access ports
`include "flash_prot_defs.vh"
module flash_prot_assertions #(
	parameter DW = 16
) (
	input wire logic          core_clk,
	input wire logic          resetn,
	input wire logic          acc_req,
	input wire logic          acc_write,
	input wire logic          acc_from_evt,
	input wire logic          acc_fetch_flash,
	input wire logic          acc_debug,
	input wire logic          flash_rd_en,
	input wire logic          flash_wr_en,
	input wire logic          acc_done_r,
	input wire logic          acc_refused_r,
	input wire logic [DW-1:0] acc_rdata_r,
	input wire logic          trap_req_r,
	input wire logic [DW-1:0] trap_num_r,
	input wire logic          prog_req,
	input wire logic          prog_allow,
	input wire logic          ctrl_wr_allow,
	input wire logic          debug_enable_r
);
	logic [1:0] run_cnt;
	wire        run = run_cnt == 2'd2;
	wire        cpu_rd = acc_req && !acc_write && !acc_from_evt && !acc_debug;
	// Two edges after release pass before the volatile copies govern
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			run_cnt <= 2'd0;
		else if (!run)
			run_cnt <= run_cnt + 2'd1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_ram_read_trap: assert property (run && cpu_rd && !acc_fetch_flash && !ctrl_wr_allow |=>
		trap_req_r && acc_refused_r && trap_num_r == `SW_TRAP_NUMBER && acc_rdata_r == `DUMMY_READ_DATA)
		else $error("blocked read not trapped");
	a_flash_code_read: assert property (run && cpu_rd && acc_fetch_flash |->
		flash_rd_en ##1 acc_done_r && !acc_refused_r) else $error("flash code read refused");
	a_ram_write_drop: assert property (acc_req && acc_write && !acc_fetch_flash && !acc_debug
		&& !ctrl_wr_allow |-> !flash_wr_en) else $error("protected write passed");
	a_evt_blocked: assert property (acc_req && acc_from_evt && !acc_debug && !ctrl_wr_allow |->
		!flash_rd_en && !flash_wr_en ##1 acc_refused_r && !trap_req_r) else $error("event access passed");
	a_unprot_read: assert property (run && acc_req && !acc_write && ctrl_wr_allow |-> flash_rd_en)
		else $error("open read blocked");
	a_prog_gate: assert property (prog_allow |-> prog_req && ctrl_wr_allow)
		else $error("program allowed while locked");
	a_debug_bypass: assert property (run && acc_req && acc_debug && debug_enable_r |->
		flash_rd_en || flash_wr_en) else $error("debug bypass blocked");
	a_reset_forced: assert property (run_cnt == 2'd0 |-> !prog_allow && !ctrl_wr_allow && !debug_enable_r)
		else $error("protection not forced at reset");
	a_done_follows: assert property (acc_done_r |-> $past(acc_req))
		else $error("done without request");
	cover property (trap_req_r);
	cover property (run && acc_req && acc_debug && debug_enable_r);
	cover property (prog_allow);
endmodule

bind flash_access_write_protection flash_prot_assertions #(.DW(DW)) u_flash_prot_assertions (
	.core_clk(core_clk), .resetn(resetn), .acc_req(acc_req), .acc_write(acc_write),
	.acc_from_evt(acc_from_evt), .acc_fetch_flash(acc_fetch_flash), .acc_debug(acc_debug),
	.flash_rd_en(flash_rd_en), .flash_wr_en(flash_wr_en), .acc_done_r(acc_done_r),
	.acc_refused_r(acc_refused_r), .acc_rdata_r(acc_rdata_r), .trap_req_r(trap_req_r),
	.trap_num_r(trap_num_r), .prog_req(prog_req), .prog_allow(prog_allow),
	.ctrl_wr_allow(ctrl_wr_allow), .debug_enable_r(debug_enable_r));

// file: bench/flash_array_model.sv
// Flash array partner: supplies read data to the protection block
module flash_array_model #(
	parameter logic [15:0] CELL = 16'h5AC3
) (
	input  wire logic        core_clk,
	input  wire logic        flash_rd_en,
	output logic      [15:0] flash_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] last_r = 16'h0000;
	always @(posedge core_clk) begin
		if (flash_rd_en)
			last_r <= CELL;
	end
	// Idle bus shows the inverse of the last word, so stale data cannot pass as a read
	assign flash_rdata = flash_rd_en ? CELL : ~last_r;
endmodule

// file: bench/flash_access_write_protection_tb.sv
// Testbench: flash access, debug and sector write protection
`include "flash_prot_defs.vh"
module flash_access_write_protection_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, resetn, psel, penable, pwrite, cpu_fetch_flash, err;
	logic        acc_req, acc_write, acc_from_evt, acc_fetch_flash, acc_debug, prog_req;
	logic        pready, pslverr, flash_rd_en, flash_wr_en, acc_done_r, acc_refused_r;
	logic        trap_req_r, prog_allow, ctrl_wr_allow, debug_enable_r;
	logic [2:0]  prog_sector;
	logic [23:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] flash_rdata, acc_rdata_r, trap_num_r;
	int          num_errors, tests_run;
	flash_access_write_protection u_flash_access_write_protection (.core_clk(core_clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_fetch_flash(cpu_fetch_flash), .acc_req(acc_req),
		.acc_write(acc_write), .acc_from_evt(acc_from_evt), .acc_fetch_flash(acc_fetch_flash),
		.acc_debug(acc_debug), .flash_rdata(flash_rdata), .flash_rd_en(flash_rd_en),
		.flash_wr_en(flash_wr_en), .acc_done_r(acc_done_r), .acc_refused_r(acc_refused_r),
		.acc_rdata_r(acc_rdata_r), .trap_req_r(trap_req_r), .trap_num_r(trap_num_r), .prog_req(prog_req),
		.prog_sector(prog_sector), .prog_allow(prog_allow), .ctrl_wr_allow(ctrl_wr_allow),
		.debug_enable_r(debug_enable_r));
	flash_array_model u_flash_array_model (.core_clk(core_clk), .flash_rd_en(flash_rd_en),
		.flash_rdata(flash_rdata));
	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d of %0d comparisons", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [21:0] idx, input logic [31:0] d, input logic f);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		cpu_fetch_flash <= f;
		@(posedge core_clk);
		penable <= 1'b1;
		@(negedge core_clk);
		while (pready !== 1'b1)
			@(negedge core_clk);
		rd = prdata;
		err = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [21:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0, 1'b0);
		chk(rd & mask, exp, "register");
	endtask
	task automatic spr(input logic [21:0] idx, input logic [15:0] d, input logic f);
		apb(1'b1, `IDX_SETPROT_TARGET, {10'h000, idx}, 1'b0);
		apb(1'b1, `IDX_SETPROT_DATA, {16'h0000, d}, 1'b0);
		apb(1'b1, `IDX_SETPROT_START, 32'h1, f);
	endtask
	task automatic acc(input logic w, ev, f, dbg, ok, trap);
		logic en;
		@(posedge core_clk);
		acc_req <= 1'b1;
		acc_write <= w;
		acc_from_evt <= ev;
		acc_fetch_flash <= f;
		acc_debug <= dbg;
		@(negedge core_clk);
		en = w ? flash_wr_en : flash_rd_en;
		@(posedge core_clk);
		acc_req <= 1'b0;
		@(negedge core_clk);
		chk(en, ok, "enable");
		chk({acc_done_r, acc_refused_r, trap_req_r}, {1'b1, !ok, trap}, "answer");
		if (!w)
			chk(acc_rdata_r, ok ? 16'h5AC3 : `DUMMY_READ_DATA, "read data");
		if (trap)
			chk(trap_num_r, `SW_TRAP_NUMBER, "trap number");
	endtask
	task automatic prog(input logic [2:0] s, input logic exp);
		@(posedge core_clk);
		prog_req <= 1'b1;
		prog_sector <= s;
		@(negedge core_clk);
		chk(prog_allow, exp, "program gate");
		@(posedge core_clk);
		prog_req <= 1'b0;
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_delivery();
		rchk(`IDX_ACCESS_LOCK_NV, 32'hFFFFFFFF, 32'h0000ACFF);
		rchk(`IDX_UNLOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFF);
		rchk(`IDX_RELOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFF);
		apb(1'b0, 22'h000001, 32'h0, 1'b0);
		chk({err, rd}, {1'b1, 32'h0}, "unmapped");
		spr(`IDX_UNLOCK_SLOTS_NV, 16'hFFFE, 1'b0);
		rchk(`IDX_UNLOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFF);
		rchk(`IDX_PROT_STATUS, 32'h0000FF0F, 32'h0000FF0E);
	endtask
	task automatic t_open();
		acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		prog(3'd3, 1'b1);
	endtask
	task automatic t_protect();
		apb(1'b1, `IDX_TEMP_UNLOCK_CTRL, 32'h1, 1'b1);
		spr(`IDX_ACCESS_LOCK_NV, 16'hFFFC, 1'b0);
		apb(1'b1, `IDX_TEMP_UNLOCK_CTRL, 32'h0, 1'b1);
		rchk(`IDX_ACCESS_LOCK_NV, 32'hFFFFFFFF, 32'h0000ACFC);
		rchk(`IDX_PROT_STATUS, 32'h00000003, 32'h00000001);
		chk({debug_enable_r, ctrl_wr_allow}, 2'b00, "locked");
		acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		prog(3'd3, 1'b0);
		apb(1'b1, `IDX_TEMP_UNLOCK_CTRL, 32'h1, 1'b0);
		rchk(`IDX_PROT_STATUS, 32'h00000001, 32'h00000001);
		spr(`IDX_SECTOR_LOCK_NV, 16'h0000, 1'b0);
		rchk(`IDX_SECTOR_LOCK_NV, 32'hFFFFFFFF, 32'h000000FF);
	endtask
	task automatic t_sectors();
		apb(1'b1, `IDX_TEMP_UNLOCK_CTRL, 32'h1, 1'b1);
		rchk(`IDX_PROT_STATUS, 32'h00000001, 32'h00000000);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		spr(`IDX_SECTOR_LOCK_NV, 16'h00F0, 1'b0);
		prog(3'd0, 1'b0);
		prog(3'd4, 1'b1);
		spr(`IDX_SECTOR_LOCK_NV, 16'h00FF, 1'b0);
		rchk(`IDX_SECTOR_LOCK_NV, 32'hFFFFFFFF, 32'h000000F0);
		prog(3'd0, 1'b1);
		spr(`IDX_SECTOR_LOCK_NV, 16'h00FE, 1'b0);
		prog(3'd0, 1'b0);
		spr(`IDX_SECTOR_LOCK_NV, 16'h0000, 1'b1);
		prog(3'd1, 1'b1);
		rchk(`IDX_PROT_STATUS, 32'h00000008, 32'h00000008);
	endtask
	task automatic t_chain();
		spr(`IDX_RELOCK_SLOTS_NV, 16'hFFFE, 1'b0);
		rchk(`IDX_RELOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFF);
		spr(`IDX_UNLOCK_SLOTS_NV, 16'hFFFC, 1'b0);
		rchk(`IDX_UNLOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFE);
		apb(1'b1, `IDX_TEMP_UNLOCK_CTRL, 32'h0, 1'b1);
		rchk(`IDX_PROT_STATUS, 32'h00000001, 32'h00000000);
		spr(`IDX_RELOCK_SLOTS_NV, 16'hFFFE, 1'b0);
		rchk(`IDX_RELOCK_SLOTS_NV, 32'hFFFFFFFF, 32'h0000FFFE);
		rchk(`IDX_PROT_STATUS, 32'h00000001, 32'h00000001);
	endtask
	// --------------------------------
	// Main sequence and watchdog
	// --------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		// Run needs well under a thousand cycles
		#(50 * 5000);
		num_errors++;
		summarize();
	end
	initial begin
		{resetn, psel, penable, pwrite, cpu_fetch_flash, acc_req, acc_write} = 7'h00;
		{acc_from_evt, acc_fetch_flash, acc_debug, prog_req, prog_sector} = 7'h00;
		paddr = 24'h000000;
		pwdata = 32'h00000000;
		num_errors = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk);
		chk({prog_allow, ctrl_wr_allow, debug_enable_r}, 3'b000, "forced");
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_delivery();
		t_open();
		t_protect();
		t_sectors();
		t_chain();
		summarize();
	end
endmodule
